// [hw/gpc_consts.vh]
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

// =====================================================================
// Register map
`define GPC_ADDR_WIDTH       8
`define GPC_PIN_CONTROL_ADDR 8'h3C
`define GPC_DATA_WIDTH       16

// =====================================================================
// Field positions of pin_control
`define GPC_TIMER_OUT_SEL_BIT  15
`define GPC_RSVD_HI_BIT        14
`define GPC_RSVD_LO_BIT        12
`define GPC_DIR_HI_BIT         11
`define GPC_DIR_LO_BIT         8
`define GPC_ROM_MAP_IN_BIT     7
`define GPC_SUBSYS_SEL_BIT     6
`define GPC_BUS_GRANTED_BIT    5
`define GPC_BUS_REQUEST_BIT    4
`define GPC_VALUE_HI_BIT       3
`define GPC_VALUE_LO_BIT       0

// =====================================================================
// Reset values and pin roles
`define GPC_PIN_COUNT        4
`define GPC_DIR_RESET        4'h0
`define GPC_VALUE_RESET      4'h0
`define GPC_TIMER_PIN        3
`define GPC_BRANCH_PIN       2
`define GPC_BOOT_PIN         0
`define GPC_SYNC_STAGES      2

`endif

// [hw/gpc_pin_sync.v]
`timescale 1ns/1ps
// Two-stage synchroniser, one per pin
module gpc_pin_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Pins
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;

  // =====================================================================
  // Synchroniser stages
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stageOne;
      reg stageTwo;
      // First stage feeds only the second
      always @(posedge clk) begin
        if (sys_rst) begin
          stageOne <= 1'b0;
          stageTwo <= 1'b0;
        end else begin
          stageOne <= asyncIn[i];
          stageTwo <= stageOne;
        end
      end
      assign syncOut[i] = stageTwo;
    end
  endgenerate

endmodule

// [hw/gpc_pin_driver.v]
`timescale 1ns/1ps
// Per-pin output driver with active-low enable
module gpc_pin_driver #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Settings
  input  wire [WIDTH-1:0] dirOut,
  input  wire [WIDTH-1:0] levelOut,
  // Pins
  output reg  [WIDTH-1:0] pinOut,
  output reg  [WIDTH-1:0] pinOe_n
);

  // =====================================================================
  // Registered pin drive, released at reset
  always @(posedge clk) begin
    if (sys_rst) begin
      pinOut  <= {WIDTH{1'b0}};
      pinOe_n <= {WIDTH{1'b1}};
    end else begin
      pinOut  <= levelOut;
      pinOe_n <= ~dirOut;
    end
  end

endmodule

// [hw/gpc_control_port.v]
// Summary of operation
// (R01) Each of the four pins is set as input or output by software.
// (R02) Reset makes every pin an input with all direction bits cleared.
// (R03) Pin data and control live in one 16-bit register at address 3Ch.
// (R04) With bit 15 set, pin 3 carries the timer output and reads it back.
// (R05) Bits 14 to 12 read as zero and ignore writes.
// (R06) Bits 11 to 8 set pin direction, 0 input and 1 output.
// (R07) Bits 3 to 0 drive output pins and return sampled levels of input pins.
// (R08) Bit 7 maps the ROM into program space; it resets to the boot-mode level.
// (R09) In external-bus boot mode the ROM bit takes the sampled pin 0 level.
// (R10) Bit 6 reads a constant naming the core, 0 for A and 1 for B.
// (R11) Bit 5 reads 1 while the external memory interface is granted to this core.
// (R12) Software sets bit 4 to request the external memory interface and clears it after.
// (R13) Pin 2, while an input, is the branch condition for conditional instructions.
// (R14) The timer output reaches pin 3 only in host-port mode.
// (R15) Pin inputs pass a two-stage synchroniser before use.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpc_consts.vh"

module gpc_control_port #(
  parameter [0:0] SUBSYSTEM_ID = 1'b0,
  parameter       PIN_COUNT    = `GPC_PIN_COUNT
) (
  // Clock and reset
  input  wire                         clk,
  input  wire                         sys_rst,
  // Register port
  input  wire [`GPC_ADDR_WIDTH-1:0]   regAddr,
  input  wire [`GPC_DATA_WIDTH-1:0]   regWrData,
  input  wire                         regWrite,
  input  wire                         regRead,
  output reg  [`GPC_DATA_WIDTH-1:0]   regRdData,
  // Device mode and neighbours
  input  wire                         bootstrapExtMode,
  input  wire                         timerOut,
  input  wire                         extBusGranted,
  output wire                         extBusRequest,
  output wire                         romMapIn,
  output wire                         branchConditionInput,
  // Pins
  input  wire [PIN_COUNT-1:0]         pinIn,
  output wire [PIN_COUNT-1:0]         pinOut,
  output wire [PIN_COUNT-1:0]         pinOe_n
);

  // =====================================================================
  // Control state
  reg                  timerOutSelect;
  reg [PIN_COUNT-1:0]  pinDirection;
  reg [PIN_COUNT-1:0]  pinValue;
  reg                  romBit;
  reg                  busRequest;
  reg  [1:0]           bootWait;

  wire [PIN_COUNT-1:0] pinSync;
  wire                 selHit;
  wire                 timerActive;
  reg  [PIN_COUNT-1:0] effDir;
  reg  [PIN_COUNT-1:0] effLevel;
  reg  [PIN_COUNT-1:0] readValue;
  reg  [`GPC_DATA_WIDTH-1:0] next_rdData;

  // Address decode
  assign selHit = (regAddr == `GPC_PIN_CONTROL_ADDR); // R03

  // Timer mux active only in host-port mode
  assign timerActive = timerOutSelect & ~bootstrapExtMode; // R04 R14

  // =====================================================================
  // Input synchroniser
  gpc_pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  ); // R15

  // =====================================================================
  // Register writes and reset
  always @(posedge clk) begin
    if (sys_rst) begin
      timerOutSelect  <= 1'b0;
      pinDirection    <= `GPC_DIR_RESET; // R02
      pinValue        <= `GPC_VALUE_RESET;
      romBit          <= bootstrapExtMode; // R08
      busRequest      <= 1'b0;
      bootWait        <= 2'h3;
    end else begin
      // Wait until the synchroniser holds pin 0, then load the ROM bit once
      if (bootWait != 2'h0) begin
        bootWait <= bootWait - 2'h1;
      end
      if (bootWait == 2'h1) begin
        if (bootstrapExtMode) begin
          romBit <= pinSync[`GPC_BOOT_PIN]; // R09
        end else begin
          romBit <= 1'b0; // R08
        end
      end
      if (regWrite && selHit) begin
        bootWait       <= 2'h0;
        timerOutSelect <= regWrData[`GPC_TIMER_OUT_SEL_BIT];
        pinDirection   <= regWrData[`GPC_DIR_HI_BIT:`GPC_DIR_LO_BIT]; // R01 R06
        pinValue       <= regWrData[`GPC_VALUE_HI_BIT:`GPC_VALUE_LO_BIT]; // R07
        romBit         <= regWrData[`GPC_ROM_MAP_IN_BIT]; // R08
        busRequest     <= regWrData[`GPC_BUS_REQUEST_BIT]; // R12
      end
    end
  end

  // =====================================================================
  // Effective pin direction, drive level and read-back
  always @* begin
    effDir    = pinDirection; // R06
    effLevel  = pinValue; // R07
    readValue = (pinDirection & pinValue) | (~pinDirection & pinSync); // R07
    if (timerActive) begin
      effDir[`GPC_TIMER_PIN]    = 1'b1; // R04
      effLevel[`GPC_TIMER_PIN]  = timerOut; // R04
      readValue[`GPC_TIMER_PIN] = timerOut; // R04
    end
  end

  // =====================================================================
  // Output drivers
  gpc_pin_driver #(
    .WIDTH (PIN_COUNT)
  ) u_drv (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .dirOut   (effDir),
    .levelOut (effLevel),
    .pinOut   (pinOut),
    .pinOe_n  (pinOe_n)
  );

  // =====================================================================
  // Read data assembly
  always @* begin
    next_rdData = {`GPC_DATA_WIDTH{1'b0}}; // R05
    next_rdData[`GPC_TIMER_OUT_SEL_BIT] = timerOutSelect;
    next_rdData[`GPC_DIR_HI_BIT:`GPC_DIR_LO_BIT] = pinDirection;
    next_rdData[`GPC_ROM_MAP_IN_BIT] = romBit;
    next_rdData[`GPC_SUBSYS_SEL_BIT] = SUBSYSTEM_ID; // R10
    next_rdData[`GPC_BUS_GRANTED_BIT] = extBusGranted; // R11
    next_rdData[`GPC_BUS_REQUEST_BIT] = busRequest;
    next_rdData[`GPC_VALUE_HI_BIT:`GPC_VALUE_LO_BIT] = readValue; // R07
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= {`GPC_DATA_WIDTH{1'b0}};
    end else if (regRead && selHit) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= {`GPC_DATA_WIDTH{1'b0}};
    end
  end

  // =====================================================================
  // Side outputs
  assign extBusRequest        = busRequest; // R12
  assign romMapIn             = romBit; // R08
  // Branch condition follows pin 2 only while it is an input
  assign branchConditionInput = ~pinDirection[`GPC_BRANCH_PIN] & pinSync[`GPC_BRANCH_PIN]; // R13

endmodule

// [testbench/gpc_pin_board.sv]
`timescale 1ns/1ps
// ==========
// Board around the four pins
module gpc_pin_board (
  // Design side
  input  wire [3:0] pinOut,
  input  wire [3:0] pinOe_n,
  // Board side
  input  wire [3:0] extLevel,
  output wire [3:0] pinIn
);
  // Wire level: design drive wins, else board drive
  assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extLevel);
endmodule

// [testbench/gpc_sva.sv]
`timescale 1ns/1ps
// ==========
// Port checker
module gpc_sva #(
  parameter [0:0] SUBSYSTEM_ID = 1'b0
) (
  // Clock, reset, register port
  input wire        clk,
  input wire        sys_rst,
  input wire [7:0]  regAddr,
  input wire [15:0] regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [15:0] regRdData,
  // Mode and pins
  input wire        extBusGranted,
  input wire        bootstrapExtMode,
  input wire        timerOut,
  input wire        branchConditionInput,
  input wire [3:0]  pinIn,
  input wire [3:0]  pinOut,
  input wire [3:0]  pinOe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Port write, then a quiet cycle
  sequence s_wr(bit t);
    regWrite && regAddr == 8'h3C && regWrData[15] == t && !bootstrapExtMode
      ##1 !regWrite && !bootstrapExtMode;
  endsequence
  // Port read one cycle back
  sequence s_rd;
    $past(regRead) && $past(regAddr) == 8'h3C;
  endsequence
  a_rsvd_zero: assert property (regRdData[14:12] == 3'h0)
    else $error("reserved bits set");
  a_read_stands: assert property (!$past(regRead) |-> regRdData == 16'h0000)
    else $error("stray read data");
  a_core_id: assert property (s_rd |-> regRdData[6] == SUBSYSTEM_ID)
    else $error("core id bit");
  a_grant_live: assert property (s_rd |-> regRdData[5] == $past(extBusGranted))
    else $error("grant bit");
  a_reset_inputs: assert property (disable iff (1'b0) sys_rst |=> pinOe_n == 4'hF)
    else $error("pin driven at reset");
  a_gpio_drive: assert property (s_wr(1'b0) |=> pinOe_n == ~$past(regWrData[11:8], 2) &&
    (pinOut & ~pinOe_n) == ($past(regWrData[3:0], 2) & ~pinOe_n))
    else $error("pin drive");
  a_timer_pin: assert property (s_wr(1'b1) |=> !pinOe_n[3] && pinOut[3] == $past(timerOut))
    else $error("timer on pin 3");
  a_branch_pin: assert property (!sys_rst [*3] ##1 pinOe_n[2] |->
    $past(branchConditionInput) == $past(pinIn[2], 3))
    else $error("branch input");
endmodule

bind gpc_control_port gpc_sva #(.SUBSYSTEM_ID(SUBSYSTEM_ID)) u_sva (.clk, .sys_rst, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .extBusGranted, .bootstrapExtMode, .timerOut,
  .branchConditionInput, .pinIn, .pinOut, .pinOe_n);

// [testbench/gpio_control_port_tb.sv]
`timescale 1ns/1ps
// ==========
// Bench
module gpio_control_port_tb;
  reg         clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  reg         bootstrapExtMode = 1'b0, timerOut = 1'b0, extBusGranted = 1'b0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [15:0] regWrData = 16'h0000;
  reg  [3:0]  extLevel = 4'h0;
  wire [15:0] regRdData;
  wire        extBusRequest, romMapIn, branchConditionInput;
  wire [3:0]  pinIn, pinOut, pinOe_n;
  integer     fails = 0, num_checks = 0, cycles = 0;

  gpc_control_port uut (.clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .bootstrapExtMode, .timerOut, .extBusGranted, .extBusRequest, .romMapIn,
    .branchConditionInput, .pinIn, .pinOut, .pinOe_n);
  gpc_pin_board board (.pinOut, .pinOe_n, .extLevel, .pinIn);

  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      fails = fails + 1;
      give_verdict;
    end
  end

  // Compare and bus cycles
  task chk(input string name, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        $display("Error %0s expected %h seen %h", name, exp, got);
        fails = fails + 1;
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk) begin regAddr <= a; regWrData <= d; regWrite <= 1'b1; end
      @(posedge clk) regWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] exp);
    begin
      @(posedge clk) begin regAddr <= a; regRead <= 1'b1; end
      @(posedge clk) regRead <= 1'b0;
      #1 chk("regRdData", exp, regRdData);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  // Scenarios
  task t_reset;
    begin
      chk("pinOe_n", 16'h000F, {12'h000, pinOe_n});
      rd(8'h3C, 16'h0000);
    end
  endtask
  task t_gpio;
    begin
      extLevel <= 4'hF;
      extBusGranted <= 1'b1;
      wr(8'h3C, 16'h7AF0);
      settle;
      chk("pinOe_n", 16'h0005, {12'h000, pinOe_n});
      chk("pinOut", 16'h0000, {12'h000, pinOut & 4'hA});
      chk("side outs", 16'h0007, {13'h0000, extBusRequest, romMapIn, branchConditionInput});
      rd(8'h3C, 16'h0AB5);
      wr(8'h3D, 16'h0F00);
      rd(8'h3E, 16'h0000);
      rd(8'h3C, 16'h0AB5);
    end
  endtask
  task t_timer;
    begin
      wr(8'h3C, 16'h8000);
      settle;
      chk("pin3", 16'h0000, {14'h0000, pinOe_n[3], pinOut[3]});
      rd(8'h3C, 16'h8027);
      timerOut <= 1'b1;
      settle;
      chk("pin3", 16'h0001, {14'h0000, pinOe_n[3], pinOut[3]});
      bootstrapExtMode <= 1'b1;
      settle;
      chk("pin3 enable", 16'h0001, {15'h0000, pinOe_n[3]});
      rd(8'h3C, 16'h802F);
    end
  endtask

  task t_boot(input lvl);
    begin
      @(posedge clk) begin sys_rst <= 1'b1; extLevel <= {3'h0, lvl}; end
      repeat (6) @(posedge clk);
      #1 chk("romMapIn reset", 16'h0001, {15'h0000, romMapIn});
      @(posedge clk) begin sys_rst <= 1'b0; extBusGranted <= 1'b0; end
      repeat (4) @(posedge clk);
      #1 chk("romMapIn boot", {15'h0000, lvl}, {15'h0000, romMapIn});
      rd(8'h3C, {8'h00, lvl, 6'h00, lvl});
    end
  endtask

  // Verdict
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_gpio;
    t_timer;
    t_boot(1'b1);
    t_boot(1'b0);
    give_verdict;
  end
endmodule
